// ==== hw/ifc_pkg.sv ====
// Constants, field layout and request carrier for the IDE function configuration header
package ifc_pkg;

   // Configuration byte offsets of the words held here
   localparam logic [7:0] OFS_MAKER_ID = 8'h00;
   localparam logic [7:0] OFS_FUNC_ID = 8'h02;
   localparam logic [7:0] OFS_COMMAND = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h06;

   // Dword selects derived from the byte offsets (address bits 7:2)
   localparam logic [5:0] DW_IDENT = OFS_MAKER_ID[7:2];
   localparam logic [5:0] DW_CMDSTS = OFS_COMMAND[7:2];

   // Command field positions
   localparam int CMD_PORT_DECODE_BIT = 0;
   localparam int CMD_BUS_MASTER_BIT = 2;
   localparam logic [15:0] CMD_RESET = 16'h0000;

   // Status field positions
   localparam int STS_MASTER_ABORT_BIT = 13;
   localparam int STS_RCVD_TABORT_BIT = 12;
   localparam int STS_SIG_TABORT_BIT = 11;
   localparam int STS_FLAG_LO = 11;
   localparam int STS_FLAG_COUNT = 3;
   localparam logic [1:0] STS_DECODE_TIMING = 2'h1;
   localparam logic STS_B2B_ACCEPT = 1'b1;
   localparam logic [15:0] STS_RESET = 16'h0280;

   // Access answer delay in clock cycles
   localparam int ACK_LATENCY = 1;

   // One configuration access as seen by the function
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] byteEn;
      logic [31:0] wdata;
   } ifc_cfg_req_t;

   // Bus-master events reported by the IDE datapath
   typedef struct packed {
      logic masterAbort;
      logic rcvdTargetAbort;
      logic sigTargetAbort;
   } ifc_abort_evt_t;

endpackage

// ==== hw/ifc_w1c_flag.sv ====
// Sticky status flag that hardware sets and software clears by writing one
module ifc_w1c_flag
   import ifc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic setEvt,
   input wire logic clrReq,
   output logic flag_q
);

   logic flag_d;

   // Set wins over a clear in the same cycle so no event is lost
   assign flag_d = setEvt | (flag_q & ~clrReq);

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
      end
   end

endmodule // ifc_w1c_flag

// ==== hw/ifc_config_header.sv ====
// Configuration header of the IDE function: identity words, command and status
//
// How it works
// - Function identity word is read only
// - Command resets zero, unused bits read zero
// - Command bit 2 permits bus mastering
// - Command bit 0 enables all port decode
// - Status resets to 0280h
// - Bit 13 sets on master abort, W1C
// - Bit 12 sets on received target abort
// - Bit 11 sets on signaled target abort
// - Bits 10:9 always read 01
// - Bit 7 reads constant one
// - Bits 15,14,8,6:0 read zero
// - Maker identity word read only at 00h
module ifc_config_header
   import ifc_pkg::*;
#(
   parameter logic [15:0] MAKER_ID = 16'h1a2b, // Arbitrary value
   parameter logic [15:0] FUNC_ID = 16'h3c4d // Arbitrary value
)
(
   input wire logic clk,
   input wire logic rst,
   input wire ifc_cfg_req_t cfgReq,
   output logic cfgAck_q,
   output logic [31:0] cfgRdData_q,
   input wire ifc_abort_evt_t abortEvt,
   input wire logic legacyPortHit,
   input wire logic bmRegPortHit,
   input wire logic bmRequest,
   output logic ioClaim_q,
   output logic busMasterGrant_q,
   output logic busMasterPermit_q,
   output logic portDecodeEnable_q
);

   // Address decode of the configuration access
   wire logic [5:0] dwSel = cfgReq.addr[7:2];
   wire logic hitIdent = (dwSel == DW_IDENT);
   wire logic hitCmdSts = (dwSel == DW_CMDSTS);
   wire logic anyAccess = cfgReq.rd | cfgReq.wr;

   // Command writes land only through byte lane 0; lane 1 holds nothing writable
   wire logic cmdWrite = cfgReq.wr & hitCmdSts & cfgReq.byteEn[0];
   // Status flags live in lane 3, the high byte of the status word
   wire logic stsWrite = cfgReq.wr & hitCmdSts & cfgReq.byteEn[3];

   // Flag vector, bit 0 is the lowest flag position
   logic [STS_FLAG_COUNT-1:0] stsFlag_q;
   wire logic [STS_FLAG_COUNT-1:0] stsSet = {abortEvt.masterAbort, abortEvt.rcvdTargetAbort,
                                             abortEvt.sigTargetAbort};
   wire logic [STS_FLAG_COUNT-1:0] stsClr;

   assign stsClr = stsWrite ? cfgReq.wdata[16+STS_FLAG_LO +: STS_FLAG_COUNT] : '0;

   genvar gi;
   generate
      for (gi = 0; gi < STS_FLAG_COUNT; gi++) begin : gFlag
         ifc_w1c_flag uFlag (
            .clk(clk),
            .rst(rst),
            .setEvt(stsSet[gi]),
            .clrReq(stsClr[gi]),
            .flag_q(stsFlag_q[gi])
         );
      end
   endgenerate

   // hardwired fields around the flags; with the flags clear this is the reset value
   wire logic [15:0] statusWord;
   assign statusWord = {2'h0, // Parity and system error reporting are not built
                        stsFlag_q, // Sticky abort flags, bits 13 to 11
                        STS_DECODE_TIMING, // Medium decode timing, positive decode only
                        1'b0, // Data parity flag not built
                        STS_B2B_ACCEPT, // Accepts back-to-back transfers as a target
                        7'h00}; // Reserved

   // only two command bits exist; the rest read zero
   wire logic [15:0] commandWord;
   assign commandWord = CMD_RESET | (16'(busMasterPermit_q) << CMD_BUS_MASTER_BIT)
                      | (16'(portDecodeEnable_q) << CMD_PORT_DECODE_BIT);

   // identity words are constants, never written
   wire logic [31:0] identDword = {FUNC_ID, MAKER_ID};
   wire logic [31:0] cmdStsDword = {statusWord, commandWord};

   // Read mux; unmapped dwords read zero
   wire logic [31:0] rdMux = hitIdent ? identDword : (hitCmdSts ? cmdStsDword : 32'h0000_0000);

   // Next command bits
   logic busMasterPermit_d;
   logic portDecodeEnable_d;
   assign busMasterPermit_d = cmdWrite ? cfgReq.wdata[CMD_BUS_MASTER_BIT] : busMasterPermit_q;
   assign portDecodeEnable_d = cmdWrite ? cfgReq.wdata[CMD_PORT_DECODE_BIT] : portDecodeEnable_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         busMasterPermit_q <= CMD_RESET[CMD_BUS_MASTER_BIT];
         portDecodeEnable_q <= CMD_RESET[CMD_PORT_DECODE_BIT];
      end else begin
         busMasterPermit_q <= busMasterPermit_d;
         portDecodeEnable_q <= portDecodeEnable_d;
      end
   end

   // Every access answers one cycle later; read data held until the next read
   always_ff @(posedge clk) begin
      if (rst) begin
         cfgAck_q <= 1'b0;
         cfgRdData_q <= 32'h0000_0000;
      end else begin
         cfgAck_q <= anyAccess;
         if (cfgReq.rd) begin
            cfgRdData_q <= rdMux;
         end
      end
   end

   // claim decode only while enabled; both legacy and bus-master ports
   wire logic ioClaim_d = portDecodeEnable_q & (legacyPortHit | bmRegPortHit);
   wire logic busMasterGrant_d = busMasterPermit_q & bmRequest;

   // the permit and decode gate rely on software ordering the base address first
   always_ff @(posedge clk) begin
      if (rst) begin
         ioClaim_q <= 1'b0;
         busMasterGrant_q <= 1'b0;
      end else begin
         ioClaim_q <= ioClaim_d;
         busMasterGrant_q <= busMasterGrant_d;
      end
   end

   // Checks on the header behaviour
   default clocking cbHdr @(posedge clk);
   endclocking

   chk_ident_read_value: assert property (
      disable iff (rst) (cfgReq.rd && hitIdent) |=> (cfgAck_q && cfgRdData_q == {FUNC_ID, MAKER_ID}))
      else $error("Identity read returned a wrong value");

   chk_ident_write_ignored: assert property (
      disable iff (rst) (cfgReq.wr && hitIdent) ##[1:2] (cfgReq.rd && hitIdent)
         |=> (cfgRdData_q[15:0] == MAKER_ID))
      else $error("Maker identity word changed after a write");

   chk_func_write_ignored: assert property (
      disable iff (rst) (cfgReq.wr && hitIdent) ##[1:2] (cfgReq.rd && hitIdent)
         |=> (cfgRdData_q[31:16] == FUNC_ID))
      else $error("Function identity word changed after a write");

   chk_cmd_unused_zero: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts) |=> ((cfgRdData_q[15:0] & 16'hfffa) == 16'h0000))
      else $error("Unimplemented command bit read as one");

   chk_cmd_read_back: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts)
         |=> (cfgRdData_q[CMD_BUS_MASTER_BIT] == $past(busMasterPermit_q)
              && cfgRdData_q[CMD_PORT_DECODE_BIT] == $past(portDecodeEnable_q)))
      else $error("Command read back differs from the command bits");

   chk_cmd_lane_gate: assert property (
      disable iff (rst) (cfgReq.wr && hitCmdSts && !cfgReq.byteEn[0])
         |=> ($stable(busMasterPermit_q) && $stable(portDecodeEnable_q)))
      else $error("Command changed by a write without lane 0");

   chk_cmd_after_reset: assert property (
      rst |=> (!busMasterPermit_q && !portDecodeEnable_q))
      else $error("Command bits not zero after reset");

   chk_bm_gate_off: assert property (
      disable iff (rst) (cmdWrite && !cfgReq.wdata[CMD_BUS_MASTER_BIT]) |-> ##2 !busMasterGrant_q)
      else $error("Mastering granted after permit cleared");

   chk_bm_gate_on: assert property (
      disable iff (rst) (cmdWrite && cfgReq.wdata[CMD_BUS_MASTER_BIT]) ##1 bmRequest |=> busMasterGrant_q)
      else $error("Mastering refused while permitted");

   chk_permit_write_lands: assert property (
      disable iff (rst) cmdWrite
         |=> (busMasterPermit_q == $past(cfgReq.wdata[CMD_BUS_MASTER_BIT])))
      else $error("Bus master permit not written");

   chk_grant_follows_request: assert property (
      disable iff (rst) (busMasterPermit_q && bmRequest)
         |=> busMasterGrant_q)
      else $error("Permitted request not granted");

   chk_grant_needs_request: assert property (
      disable iff (rst) !bmRequest
         |=> !busMasterGrant_q)
      else $error("Grant without a request");

   chk_decode_gate: assert property (
      disable iff (rst) (!portDecodeEnable_q && !cmdWrite) |=> !$past(ioClaim_d) ##0 !ioClaim_q)
      else $error("Port claimed while decode disabled");

   chk_decode_both_ports: assert property (
      disable iff (rst) (portDecodeEnable_q && (legacyPortHit || bmRegPortHit)) |=> ioClaim_q)
      else $error("Enabled decode missed a port hit");

   chk_decode_write_lands: assert property (
      disable iff (rst) cmdWrite
         |=> (portDecodeEnable_q == $past(cfgReq.wdata[CMD_PORT_DECODE_BIT])))
      else $error("Port decode enable not written");

   chk_claim_needs_hit: assert property (
      disable iff (rst) (!legacyPortHit && !bmRegPortHit)
         |=> !ioClaim_q)
      else $error("Port claimed without a port hit");

   chk_status_reset: assert property (
      rst |=> (statusWord == STS_RESET))
      else $error("Status not at reset value");

   chk_master_abort_set: assert property (
      disable iff (rst) (abortEvt.masterAbort ##1 !stsClr[2])
         |-> statusWord[STS_MASTER_ABORT_BIT] ##1 statusWord[STS_MASTER_ABORT_BIT])
      else $error("Master abort flag not held");

   chk_rcvd_abort_set: assert property (
      disable iff (rst) (abortEvt.rcvdTargetAbort && !stsWrite) |=> statusWord[STS_RCVD_TABORT_BIT])
      else $error("Received target abort flag not set");

   chk_sig_abort_set: assert property (
      disable iff (rst) abortEvt.sigTargetAbort |=> statusWord[STS_SIG_TABORT_BIT])
      else $error("Signaled target abort flag not set");

   chk_flag_w1c_clear: assert property (
      disable iff (rst) (stsWrite && cfgReq.wdata[16+STS_MASTER_ABORT_BIT] && !abortEvt.masterAbort)
         |=> !statusWord[STS_MASTER_ABORT_BIT])
      else $error("Master abort flag not cleared by one");

   chk_rcvd_w1c_clear: assert property (
      disable iff (rst) (stsWrite && cfgReq.wdata[16+STS_RCVD_TABORT_BIT] && !abortEvt.rcvdTargetAbort)
         |=> !statusWord[STS_RCVD_TABORT_BIT])
      else $error("Received target abort flag not cleared by one");

   chk_sig_w1c_clear: assert property (
      disable iff (rst) (stsWrite && cfgReq.wdata[16+STS_SIG_TABORT_BIT] && !abortEvt.sigTargetAbort)
         |=> !statusWord[STS_SIG_TABORT_BIT])
      else $error("Signaled target abort flag not cleared by one");

   chk_set_beats_clear: assert property (
      disable iff (rst) (abortEvt.sigTargetAbort && stsClr[0])
         |=> statusWord[STS_SIG_TABORT_BIT])
      else $error("Clear won over a same-cycle abort");

   chk_flag_zero_keep: assert property (
      disable iff (rst) (statusWord[STS_SIG_TABORT_BIT] && stsWrite && !cfgReq.wdata[16+STS_SIG_TABORT_BIT])
         |=> statusWord[STS_SIG_TABORT_BIT])
      else $error("Flag lost on a zero write");

   chk_master_zero_keep: assert property (
      disable iff (rst) (statusWord[STS_MASTER_ABORT_BIT] && stsWrite && !cfgReq.wdata[16+STS_MASTER_ABORT_BIT])
         |=> statusWord[STS_MASTER_ABORT_BIT])
      else $error("Master abort flag lost on a zero write");

   chk_rcvd_zero_keep: assert property (
      disable iff (rst) (statusWord[STS_RCVD_TABORT_BIT] && stsWrite && !cfgReq.wdata[16+STS_RCVD_TABORT_BIT])
         |=> statusWord[STS_RCVD_TABORT_BIT])
      else $error("Received target abort flag lost on a zero write");

   chk_flag_lane_gate: assert property (
      disable iff (rst) (cfgReq.wr && hitCmdSts && !cfgReq.byteEn[3] && stsSet == 3'h0)
         |=> $stable(stsFlag_q))
      else $error("Status flag changed by a write without lane 3");

   chk_status_read_flags: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts)
         |=> (cfgRdData_q[16+STS_FLAG_LO +: STS_FLAG_COUNT] == $past(stsFlag_q)))
      else $error("Status read lost a flag");

   chk_status_fixed: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts)
         |=> (cfgRdData_q[31:16] & 16'hc7ff) == 16'h0280)
      else $error("Hardwired status fields wrong");

   chk_b2b_capable: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts)
         |=> (cfgRdData_q[16+7] && cfgRdData_q[26:25] == 2'h1))
      else $error("Status capability bits wrong");

   chk_status_zero_bits: assert property (
      disable iff (rst) (cfgReq.rd && hitCmdSts)
         |=> (cfgRdData_q[31:30] == 2'h0 && cfgRdData_q[24] == 1'b0 && cfgRdData_q[22:16] == 7'h00))
      else $error("Unimplemented status bit set");

   // Main scenarios reached
   cov_flag_set_clear: cover property (disable iff (rst) abortEvt.masterAbort ##[1:20] stsClr[2]);
   cov_set_clear_same: cover property (disable iff (rst) stsSet[0] && stsClr[0]);
   cov_bm_grant: cover property (disable iff (rst) busMasterGrant_q);
   cov_io_claim: cover property (disable iff (rst) ioClaim_q && $past(bmRegPortHit));
   cov_cmd_lane_closed: cover property (disable iff (rst) cfgReq.wr && hitCmdSts && !cfgReq.byteEn[0]);

endmodule // ifc_config_header

// ==== verification/ifc_host_model.sv ====
// Configuration host model that issues single accesses to the function header
module ifc_host_model
   import ifc_pkg::*;
(
   input wire logic clk,
   output ifc_cfg_req_t cfgReq,
   input wire logic cfgAck_q,
   input wire logic [31:0] cfgRdData_q
);
   timeunit 1ns;
   timeprecision 1ps;

   initial cfgReq = '0;

   // software order: base address set up before decode enable is written
   // One access held for one taking edge; the answer comes one cycle later
   task automatic access(input logic rd, input logic wr, input logic [7:0] a, input logic [3:0] be,
         input logic [31:0] wd, output logic [31:0] data, output logic acked);
      @(posedge clk);
      cfgReq <= '{rd: rd, wr: wr, addr: a, byteEn: be, wdata: wd};
      @(posedge clk);
      // Released lines show no stale value
      cfgReq <= '{rd: 1'b0, wr: 1'b0, addr: ~a, byteEn: 4'h0, wdata: ~wd};
      #1;
      acked = cfgAck_q;
      data = cfgRdData_q;
   endtask
endmodule // ifc_host_model

// ==== verification/test_ide_function_pci_config_header.sv ====
// Self-checking bench for the IDE function configuration header
module test_ide_function_pci_config_header
   import ifc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] MAKER = 16'h5e71; // Arbitrary value
   localparam logic [15:0] FUNC = 16'h9a04; // Arbitrary value
   logic clk, rst, legacyPortHit, bmRegPortHit, bmRequest, ack;
   logic cfgAck_q, ioClaim_q, busMasterGrant_q, busMasterPermit_q, portDecodeEnable_q;
   logic [31:0] cfgRdData_q, rdv;
   logic [15:0] cmdExp;
   logic [2:0] flg;
   ifc_cfg_req_t cfgReq;
   ifc_abort_evt_t abortEvt;
   int errorCnt = 0;
   int totalChecks = 0;

   ifc_config_header #(.MAKER_ID(MAKER), .FUNC_ID(FUNC)) dut_u (.clk(clk), .rst(rst), .cfgReq(cfgReq),
      .cfgAck_q(cfgAck_q), .cfgRdData_q(cfgRdData_q), .abortEvt(abortEvt), .legacyPortHit(legacyPortHit),
      .bmRegPortHit(bmRegPortHit), .bmRequest(bmRequest), .ioClaim_q(ioClaim_q),
      .busMasterGrant_q(busMasterGrant_q), .busMasterPermit_q(busMasterPermit_q),
      .portDecodeEnable_q(portDecodeEnable_q));
   ifc_host_model hostU (.clk(clk), .cfgReq(cfgReq), .cfgAck_q(cfgAck_q), .cfgRdData_q(cfgRdData_q));

   // Compare and count
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic printVerdict();
      $display("checks %0d errors %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Expected command and status dword from the tracked command and flags
   function automatic logic [31:0] cmdSts();
      return {2'b00, flg, 2'b01, 1'b0, 1'b1, 7'h00, cmdExp};
   endfunction

   // Every access must be answered one cycle after it is taken
   task automatic xfer(input logic rd, input logic wr, input logic [7:0] a, input logic [3:0] be,
         input logic [31:0] wd);
      hostU.access(rd, wr, a, be, wd, rdv, ack);
      check("ack", {31'h0, ack}, 32'h1);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Watchdog: the sequence needs a few hundred cycles
   initial begin
      #200us;
      errorCnt++;
      printVerdict();
   end

   initial begin
      logic [31:0] r;
      r = $urandom(32'h14c9);
      rst = 1'b1;
      legacyPortHit = 1'b0;
      bmRegPortHit = 1'b0;
      bmRequest = 1'b0;
      abortEvt = '0;
      cmdExp = 16'h0000;
      flg = 3'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
      check("reset cmdsts", rdv, cmdSts());
      xfer(1'b0, 1'b1, OFS_MAKER_ID, 4'hf, 32'hffffffff);
      xfer(1'b1, 1'b0, OFS_FUNC_ID, 4'hf, 32'h0);
      check("ident", rdv, {FUNC, MAKER});
      xfer(1'b1, 1'b0, 8'h10, 4'hf, 32'h0);
      check("unmapped", rdv, 32'h0);
      // Hardwired and reserved bits ignore ones; bits 1 and 3 set, 0 and 2 clear
      xfer(1'b0, 1'b1, OFS_COMMAND, 4'hf, 32'hfffffffa);
      xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
      check("ignored ones", rdv, cmdSts());
      // Each abort sets its flag; zero writes and a closed lane keep it; one clears it
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         abortEvt <= 3'b100 >> k;
         @(posedge clk);
         abortEvt <= '0;
         flg[2-k] = 1'b1;
         xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
         check("flag set", rdv, cmdSts());
         xfer(1'b0, 1'b1, OFS_COMMAND, 4'hf, {16'h0000, cmdExp});
         xfer(1'b0, 1'b1, OFS_COMMAND, 4'h7, {16'h3800, cmdExp});
         xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
         check("flag kept", rdv, cmdSts());
         xfer(1'b0, 1'b1, OFS_COMMAND, 4'h8, 32'h1 << (29 - k));
         flg[2-k] = 1'b0;
         xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
         check("flag cleared", rdv, cmdSts());
      end
      // Abort and a one-write taken at the same edge: the set wins
      fork
         xfer(1'b0, 1'b1, OFS_COMMAND, 4'h8, 32'h0800_0000);
         begin
            @(posedge clk);
            abortEvt <= 3'b001;
            @(posedge clk);
            abortEvt <= '0;
         end
      join
      flg[0] = 1'b1;
      xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
      check("set wins", rdv, cmdSts());
      xfer(1'b0, 1'b1, OFS_COMMAND, 4'h8, 32'h0800_0000);
      flg[0] = 1'b0;
      // Base address lives outside this header; it is written before decode is ever enabled
      xfer(1'b0, 1'b1, 8'h20, 4'hf, 32'h0000_fff1);
      // Random command values gate decode and mastering
      for (int i = 0; i < 40; i++) begin
         r = $urandom();
         cmdExp = {13'h0, r[2], 1'b0, r[0]};
         xfer(1'b0, 1'b1, OFS_COMMAND, 4'h1, {16'h0000, r[15:0]});
         xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
         check("cmd", rdv, cmdSts());
         check("permit", {31'h0, busMasterPermit_q}, {31'h0, r[2]});
         check("decode", {31'h0, portDecodeEnable_q}, {31'h0, r[0]});
         @(posedge clk);
         legacyPortHit <= r[16];
         bmRegPortHit <= r[17];
         bmRequest <= r[18];
         @(posedge clk);
         #1;
         check("claim", {31'h0, ioClaim_q}, {31'h0, r[0] & (r[16] | r[17])});
         check("grant", {31'h0, busMasterGrant_q}, {31'h0, r[2] & r[18]});
      end
      // Second reset in mid-run returns command and a freshly set flag to zero
      @(posedge clk);
      abortEvt <= 3'b010;
      @(posedge clk);
      abortEvt <= '0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      cmdExp = 16'h0000;
      xfer(1'b1, 1'b0, OFS_COMMAND, 4'hf, 32'h0);
      check("rereset", rdv, cmdSts());
      printVerdict();
   end
endmodule // test_ide_function_pci_config_header
